/* File: src/hfs_frame_status.sv */
/*
 * hdlc receive-status and address-recognition block with apb registers.
 * assumes receiver and transmitter event inputs are one-cycle pulses
 * synchronous to clk, and that the receive queue always takes the copy.
 */
// Chosen here: the APB interface to the registers.
// Summary of operation
// - receiver active set on flag, cleared on abort
// - valid frame only when bit count aligned
// - flag overflow when frame bytes dropped
// - transmitter active from xtf until frame sent
// - report crc good or bad
// - flag abort on seven ones
// - compare sapi with two values and group
// - compare tei with two values and group
// - one-byte address: tei_prog_first gives 1, tei_prog_second 0
// - two-byte address match encoding table
// - copy command/response bit from sapi byte
// - status shows last frame, copied into queue
// - equal sapi values never yield 001
// - read-only status, reserved zero, reset value
// - message end event at frame end
`timescale 1ns/1ns
module hfs_frame_status (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_open_flag,
    input  wire logic        rx_abort,
    input  wire logic        rx_frame_end,
    input  wire logic        rx_bits_aligned,
    input  wire logic        rx_crc_good,
    input  wire logic        rx_byte_drop,
    input  wire logic        rx_byte_valid,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        transparent_tx_cmd,
    input  wire logic        tx_frame_sent,
    output logic             queue_status_valid,
    output logic      [15:0] queue_status_data,
    output logic             irq
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [15:0]           frame_status_reg;
    logic [15:0]           frame_status_next;
    logic [15:0]           sapi_reg;
    logic [15:0]           tei_reg;
    hfs_pkg::hfs_mode_t    mode_reg;
    logic                  two_byte_reg;
    logic [hfs_pkg::INT_W-1:0] int_stat_reg;
    logic [hfs_pkg::INT_W-1:0] int_stat_next;
    logic [hfs_pkg::INT_W-1:0] int_mask_reg;
    logic                  rx_active_reg;
    logic                  tx_active_reg;
    logic                  drop_seen_reg;
    logic [1:0]            byte_cnt_reg;
    logic [7:0]            addr_b1_reg;
    logic [7:0]            addr_b2_reg;
    logic [31:0]           prdata_reg;
    logic                  queue_valid_reg;

    hfs_match_if m_if ();

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire setup    = psel && !penable;
    wire access   = psel && penable;
    wire hit_stat = paddr == hfs_pkg::OFF_STATUS;
    wire hit_sapi = paddr == hfs_pkg::OFF_SAPI;
    wire hit_tei  = paddr == hfs_pkg::OFF_TEI;
    wire hit_mode = paddr == hfs_pkg::OFF_MODE;
    wire hit_ist  = paddr == hfs_pkg::OFF_INT_STAT;
    wire hit_imsk = paddr == hfs_pkg::OFF_INT_MASK;
    wire mapped   = hit_stat || hit_sapi || hit_tei || hit_mode ||
                    hit_ist || hit_imsk;
    // status register ignores writes; no error, it is simply read-only
    wire wr_sapi  = access && pwrite && hit_sapi;
    wire wr_tei   = access && pwrite && hit_tei;
    wire wr_mode  = access && pwrite && hit_mode;
    wire wr_imsk  = access && pwrite && hit_imsk;
    wire rd_ist   = access && !pwrite && hit_ist;
    wire [31:0] rd_mux =
        hit_stat ? {16'h0, frame_status_reg} :
        hit_sapi ? {16'h0, sapi_reg} :
        hit_tei  ? {16'h0, tei_reg} :
        hit_mode ? {27'h0, two_byte_reg, 1'b0, mode_reg} :
        hit_ist  ? {29'h0, int_stat_reg} :
        hit_imsk ? {29'h0, int_mask_reg} : 32'h0;

    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata  = prdata_reg;

    // ----------------------------------------------------------------
    // matcher hookup
    // ----------------------------------------------------------------
    assign m_if.sapi1    = sapi_reg[7:0];
    assign m_if.sapi2    = sapi_reg[15:8];
    assign m_if.tei_prog_first     = tei_reg[7:0];
    assign m_if.tei_prog_second     = tei_reg[15:8];
    assign m_if.mode     = mode_reg;
    assign m_if.two_byte = two_byte_reg;
    assign m_if.addr_b1  = addr_b1_reg;
    assign m_if.addr_b2  = addr_b2_reg;

    hfs_addr_match u_match (
        .m (m_if.matcher)
    );

    // ----------------------------------------------------------------
    // frame end and status assembly
    // ----------------------------------------------------------------
    // an abort ends the frame as a closing flag does
    wire end_evt   = rx_active_reg && (rx_frame_end || rx_abort);
    wire drop_now  = drop_seen_reg || rx_byte_drop;
    wire rx_act_nx = rx_abort ? 1'b0 :
                     rx_open_flag ? 1'b1 : rx_active_reg;
    wire tx_act_nx = transparent_tx_cmd ? 1'b1 :
                     tx_frame_sent ? 1'b0 : tx_active_reg;
    wire [15:0] frame_bits = {
        rx_bits_aligned,
        drop_now,
        rx_crc_good,
        rx_abort,
        m_if.result[2:1],
        addr_b1_reg[1],
        m_if.result[0],
        8'h0};
    // frame bits change only at frame end, activity bits every cycle
    assign frame_status_next = {
        end_evt ? frame_bits[15:8] : frame_status_reg[15:8],
        rx_act_nx, 6'h0, tx_act_nx};

    // events set, a read clears; the set wins in a colliding cycle
    wire [hfs_pkg::INT_W-1:0] int_set = {
        end_evt && drop_now, end_evt && rx_abort, end_evt};
    assign int_stat_next = (rd_ist ? '0 : int_stat_reg) | int_set;
    assign irq = |(int_stat_reg & ~int_mask_reg);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            frame_status_reg <= hfs_pkg::STATUS_RESET;
            int_stat_reg     <= '0;
            rx_active_reg    <= 1'b0;
            tx_active_reg    <= 1'b0;
        end else begin
            frame_status_reg <= frame_status_next;
            int_stat_reg     <= int_stat_next;
            rx_active_reg    <= rx_act_nx;
            tx_active_reg    <= tx_act_nx;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sapi_reg     <= 16'h0;
            tei_reg      <= 16'h0;
            mode_reg     <= hfs_pkg::HFS_AUTO;
            two_byte_reg <= 1'b0;
            int_mask_reg <= '0;
        end else begin
            if (wr_sapi) begin
                sapi_reg <= pwdata[15:0];
            end
            if (wr_tei) begin
                tei_reg <= pwdata[15:0];
            end
            if (wr_mode) begin
                mode_reg     <= hfs_pkg::hfs_mode_t'(pwdata[2:0]);
                two_byte_reg <= pwdata[hfs_pkg::BIT_TWO_BYTE];
            end
            if (wr_imsk) begin
                int_mask_reg <= pwdata[hfs_pkg::INT_W-1:0];
            end
        end
    end

    // per-frame capture: drop flag and the first two address bytes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            drop_seen_reg <= 1'b0;
            byte_cnt_reg  <= 2'h0;
            addr_b1_reg   <= 8'h0;
            addr_b2_reg   <= 8'h0;
        end else if (rx_open_flag) begin
            drop_seen_reg <= 1'b0;
            byte_cnt_reg  <= 2'h0;
        end else begin
            drop_seen_reg <= drop_now;
            if (rx_byte_valid && byte_cnt_reg == 2'h0) begin
                addr_b1_reg  <= rx_byte;
                byte_cnt_reg <= 2'h1;
            end else if (rx_byte_valid && byte_cnt_reg == 2'h1) begin
                addr_b2_reg  <= rx_byte;
                byte_cnt_reg <= 2'h2;
            end
        end
    end

    // read data registered in the setup cycle, so it is a flop output
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata_reg <= 32'h0;
        end else if (setup && !pwrite) begin
            prdata_reg <= rd_mux;
        end
    end

    // copy of the new status goes to the receive queue as a 16-bit word
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            queue_valid_reg   <= 1'b0;
            queue_status_data <= 16'h0;
        end else begin
            queue_valid_reg <= end_evt;
            if (end_evt) begin
                queue_status_data <= frame_status_next;
            end
        end
    end
    assign queue_status_valid = queue_valid_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_rx_act_set: assert property (
        rx_open_flag && !rx_abort |=> frame_status_reg[hfs_pkg::BIT_RX_ACTIVE_FLAG])
        else $error("receiver active not set after flag");
    a_rx_act_clr: assert property (
        rx_abort |=> !frame_status_reg[hfs_pkg::BIT_RX_ACTIVE_FLAG])
        else $error("receiver active not cleared by abort");
    a_valid_frame: assert property (
        end_evt |=> frame_status_reg[hfs_pkg::BIT_VFR] ==
                    $past(rx_bits_aligned))
        else $error("valid frame bit wrong");
    a_overflow_bit: assert property (
        rx_byte_drop && !rx_open_flag ##1 (!rx_open_flag && end_evt)
        |=> frame_status_reg[hfs_pkg::BIT_RDO])
        else $error("dropped byte not reported");
    a_tx_active: assert property (
        transparent_tx_cmd |=> frame_status_reg[hfs_pkg::BIT_TX_ACTIVE_FLAG]
        until $past(tx_frame_sent))
        else $error("transmitter active dropped early");
    a_crc_bit: assert property (
        end_evt |=> frame_status_reg[hfs_pkg::BIT_CRC] ==
                    $past(rx_crc_good))
        else $error("crc bit wrong");
    a_abort_bit: assert property (
        end_evt && rx_abort |=> frame_status_reg[hfs_pkg::BIT_RAB])
        else $error("abort bit not set");
    a_cr_copy: assert property (
        end_evt |=> frame_status_reg[hfs_pkg::BIT_CR] ==
                    $past(addr_b1_reg[1]))
        else $error("command/response bit not copied");
    a_queue_copy: assert property (
        end_evt |=> queue_status_valid &&
                    queue_status_data[15:8] == frame_status_reg[15:8])
        else $error("status copy to queue wrong");
    a_no_code_001: assert property (
        end_evt && sapi_reg[7:0] == sapi_reg[15:8] |=>
        {frame_status_reg[11:10], frame_status_reg[8]} != 3'h1)
        else $error("code 001 with equal sapi values");
    a_reserved_zero: assert property (
        frame_status_reg[6:1] == 6'h0)
        else $error("reserved status bits not zero");
    a_msg_end_irq: assert property (
        end_evt |=> int_stat_reg[hfs_pkg::INT_RME] ##1
        (int_stat_reg[hfs_pkg::INT_RME] || $past(rd_ist)))
        else $error("message end event lost");
    a_frame_hold: assert property (
        !end_evt |=> $stable(frame_status_reg[15:8]))
        else $error("frame bits changed outside frame end");
endmodule // hfs_frame_status

/* File: src/hfs_pkg.sv */
/*
 * constants shared by the frame status block and its address matcher.
 * assumes a 32-bit apb slave with byte addresses in an 8-bit window.
 */
package hfs_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_STATUS   = 8'h08;
    localparam logic [7:0] OFF_SAPI     = 8'h10;
    localparam logic [7:0] OFF_TEI      = 8'h14;
    localparam logic [7:0] OFF_MODE     = 8'h18;
    localparam logic [7:0] OFF_INT_STAT = 8'h1c;
    localparam logic [7:0] OFF_INT_MASK = 8'h20;
    // ----------------------------------------------------------------
    // status field positions and reset value
    // ----------------------------------------------------------------
    localparam int BIT_VFR  = 15;
    localparam int BIT_RDO  = 14;
    localparam int BIT_CRC  = 13;
    localparam int BIT_RAB  = 12;
    localparam int BIT_SA1  = 11;
    localparam int BIT_SA0  = 10;
    localparam int BIT_CR   = 9;
    localparam int BIT_TA   = 8;
    localparam int BIT_RX_ACTIVE_FLAG = 7;
    localparam int BIT_TX_ACTIVE_FLAG = 0;
    localparam logic [15:0] STATUS_RESET = 16'h0c00;
    // ----------------------------------------------------------------
    // mode register fields, interrupt bits
    // ----------------------------------------------------------------
    localparam int BIT_TWO_BYTE = 4;
    localparam int INT_RME = 0;
    localparam int INT_RAB = 1;
    localparam int INT_RDO = 2;
    localparam int INT_W   = 3;
    // ----------------------------------------------------------------
    // address comparison constants
    // ----------------------------------------------------------------
    localparam logic [5:0] SAPI_GROUP = 6'h3f;
    localparam logic [6:0] TEI_GROUP  = 7'h7f;
    localparam logic [2:0] CODE_S2_TG = 3'h0;
    localparam logic [2:0] CODE_S2_T2 = 3'h1;
    localparam logic [2:0] CODE_SG_TG = 3'h2;
    localparam logic [2:0] CODE_SG_TX = 3'h3;
    localparam logic [2:0] CODE_S1_TG = 3'h4;
    localparam logic [2:0] CODE_S1_T1 = 3'h5;
    localparam logic [2:0] CODE_NONE  = 3'h6;
    typedef enum logic [2:0] {
        HFS_AUTO, HFS_NONAUTO, HFS_TRANSP0, HFS_TRANSP1, HFS_TRANSP3
    } hfs_mode_t;
endpackage

/* File: src/hfs_match_if.sv */
/*
 * carrier between the status block and its address matcher.
 * assumes both ends sit in one clock domain; content is combinational.
 */
`timescale 1ns/1ns
interface hfs_match_if;
    logic [7:0]        sapi1;
    logic [7:0]        sapi2;
    logic [7:0]        tei_prog_first;
    logic [7:0]        tei_prog_second;
    hfs_pkg::hfs_mode_t mode;
    logic              two_byte;
    logic [7:0]        addr_b1;
    logic [7:0]        addr_b2;
    logic [2:0]        result;
    modport matcher (input sapi1, sapi2, tei_prog_first, tei_prog_second, mode, two_byte,
                     input addr_b1, addr_b2, output result);
    modport user    (output sapi1, sapi2, tei_prog_first, tei_prog_second, mode, two_byte,
                     output addr_b1, addr_b2, input result);
endinterface

/* File: src/hfs_addr_match.sv */
/*
 * address matcher: turns the first one or two address bytes into the
 * sapi/tei match code {sa1, sa0, ta}. purely combinational.
 * assumes the caller samples the result only at frame end.
 */
`timescale 1ns/1ns
module hfs_addr_match (
    hfs_match_if.matcher m
);
    // ----------------------------------------------------------------
    // comparisons; c/r and ea bits are excluded from the compare
    // ----------------------------------------------------------------
    wire s1   = m.addr_b1[7:2] == m.sapi1[7:2];
    wire s2   = m.addr_b1[7:2] == m.sapi2[7:2];
    wire sg   = m.addr_b1[7:2] == hfs_pkg::SAPI_GROUP;
    wire t1   = m.addr_b2[7:1] == m.tei_prog_first[7:1];
    wire t2   = m.addr_b2[7:1] == m.tei_prog_second[7:1];
    wire tg   = m.addr_b2[7:1] == hfs_pkg::TEI_GROUP;
    wire same = m.sapi1 == m.sapi2;
    wire one_t1 = m.addr_b1[7:1] == m.tei_prog_first[7:1];
    // the !same term on the 001 arm keeps equal sapi values from reaching 001
    wire [2:0] code2 =
        (s1 && tg)         ? hfs_pkg::CODE_S1_TG :
        (s1 && t1)         ? hfs_pkg::CODE_S1_T1 :
        (sg && tg)         ? hfs_pkg::CODE_SG_TG :
        (sg && (t1 || t2)) ? hfs_pkg::CODE_SG_TX :
        (s2 && tg)         ? hfs_pkg::CODE_S2_TG :
        (s2 && t2 && !same) ? hfs_pkg::CODE_S2_T2 :
                             hfs_pkg::CODE_NONE;
    wire sa_sig = (m.mode == hfs_pkg::HFS_NONAUTO && m.two_byte) ||
                  m.mode == hfs_pkg::HFS_TRANSP3;
    wire ta_sig = m.mode != hfs_pkg::HFS_TRANSP0 &&
                  m.mode != hfs_pkg::HFS_TRANSP1;
    wire [1:0] sa_out = sa_sig ? code2[2:1] : 2'h3;
    wire ta_out = !ta_sig ? 1'b0 :
                  m.two_byte ? code2[0] : one_t1;
    assign m.result = {sa_out, ta_out};
endmodule // hfs_addr_match

/* File: bench/hfs_remote_station.sv */
/*
 * far-side model: a remote station sending frames to the receiver.
 * assumes frame() is called right after a rising edge of clk.
 */
`timescale 1ns/1ns
module hfs_remote_station (
    input  wire logic       clk,
    output logic            rx_open_flag,
    output logic            rx_abort,
    output logic            rx_frame_end,
    output logic            rx_bits_aligned,
    output logic            rx_crc_good,
    output logic            rx_byte_drop,
    output logic            rx_byte_valid,
    output logic      [7:0] rx_byte
);
    initial begin
        {rx_open_flag, rx_abort, rx_frame_end, rx_byte_drop} = 4'h0;
        {rx_bits_aligned, rx_crc_good, rx_byte_valid} = 3'h0;
        rx_byte = 8'h00;
    end
    // ----------------------------------------------------------------
    // one frame: flag, up to two address bytes, then end or abort
    // ----------------------------------------------------------------
    task automatic frame(input logic [7:0] b1, input logic [7:0] b2,
                         input int nb, input logic al, input logic crc,
                         input logic drop, input logic ab);
        @(posedge clk);
        rx_open_flag <= 1'h1;
        @(posedge clk);
        rx_open_flag  <= 1'h0;
        rx_byte_valid <= (nb > 0);
        rx_byte       <= b1;
        @(posedge clk);
        rx_byte_valid <= (nb > 1);
        rx_byte       <= b2;
        rx_byte_drop  <= drop;
        @(posedge clk);
        // the released rx_byte line never keeps its last value
        rx_byte_valid   <= 1'h0;
        rx_byte_drop    <= 1'h0;
        rx_byte         <= ~b2;
        rx_bits_aligned <= al;
        rx_crc_good     <= crc;
        rx_frame_end    <= !ab;
        rx_abort        <= ab;
        @(posedge clk);
        rx_frame_end    <= 1'h0;
        rx_abort        <= 1'h0;
        rx_bits_aligned <= !al;
        rx_crc_good     <= !crc;
    endtask
endmodule // hfs_remote_station

/* File: bench/hdlc_frame_status_addr_match_tb.sv */
/*
 * self-checking bench for the frame status block, apb master inside.
 * assumes the remote station model drives all receive inputs.
 */
`timescale 1ns/1ns
module hdlc_frame_status_addr_match_tb;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr, rx_byte;
    logic [31:0] pwdata, prdata, s;
    logic        rx_open_flag, rx_abort, rx_frame_end, rx_bits_aligned;
    logic        rx_crc_good, rx_byte_drop, rx_byte_valid, irq;
    logic        transparent_tx_cmd, tx_frame_sent, queue_status_valid;
    logic [15:0] queue_status_data, q_last;
    int          err_count, checked, cyc;
    logic [7:0]  tb1 [8] = '{8'h80, 8'h82, 8'hfc, 8'hfe,
                            8'hfc, 8'h40, 8'h42, 8'h00};
    logic [7:0]  tb2 [8] = '{8'hff, 8'h44, 8'hff, 8'h22,
                            8'h44, 8'hff, 8'h22, 8'h00};
    logic [2:0]  tc  [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h5, 3'h6};
    logic [31:0] md  [4] = '{32'h10, 32'h12, 32'h13, 32'h14};
    logic [2:0]  mx  [4] = '{3'h6, 3'h6, 3'h6, 3'h5};
    hfs_frame_status u_hfs_frame_status (
        .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rx_open_flag, .rx_abort, .rx_frame_end,
        .rx_bits_aligned, .rx_crc_good, .rx_byte_drop, .rx_byte_valid,
        .rx_byte, .transparent_tx_cmd, .tx_frame_sent,
        .queue_status_valid, .queue_status_data, .irq);
    hfs_remote_station u_hfs_remote_station (
        .clk, .rx_open_flag, .rx_abort, .rx_frame_end, .rx_bits_aligned,
        .rx_crc_good, .rx_byte_drop, .rx_byte_valid, .rx_byte);
    always #20 clk = ~clk;
    always @(posedge clk) begin
        if (queue_status_valid === 1'h1) q_last <= queue_status_data;
        cyc <= cyc + 1;
        // ceiling well above the roughly 250 cycles the run needs
        if (cyc == 20000) begin
            err_count++;
            end_of_test;
        end
    end
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    // waits on pready with no cycle limit; only the bench ceiling ends it
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        s = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // idle edge, so a following call never re-drives psel this step
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'h0, a, 32'h0);
    endtask
    task automatic fr(input logic [7:0] b1, input logic [7:0] b2,
                      input int nb, input logic [3:0] f);
        u_hfs_remote_station.frame(b1, b2, nb, f[3], f[2], f[1], f[0]);
        rd(hfs_pkg::OFF_STATUS);
    endtask
    function automatic logic [31:0] exp_st(input logic [2:0] c,
                                           input logic cr);
        return {16'h0, 4'ha, c[2:1], cr, c[0], 8'h80};
    endfunction
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rd(hfs_pkg::OFF_STATUS);
        chk("status reset", s, 32'h0c00);
        apb(1'h1, hfs_pkg::OFF_STATUS, 32'hffff);
        rd(hfs_pkg::OFF_STATUS);
        chk("status read only", s, 32'h0c00);
        rd(8'h3c);
        chk("unmapped error", e, 32'h1);
        chk("unmapped data", s, 32'h0);
    endtask
    task automatic t_codes;
        apb(1'h1, hfs_pkg::OFF_SAPI, 32'h8040);
        apb(1'h1, hfs_pkg::OFF_TEI, 32'h4422);
        apb(1'h1, hfs_pkg::OFF_MODE, 32'h11);
        for (int i = 0; i < 8; i++) begin
            fr(tb1[i], tb2[i], 2, 4'hc);
            chk("match status", s, exp_st(tc[i], tb1[i][1]));
            chk("queue copy", q_last, s[15:0]);
        end
        apb(1'h1, hfs_pkg::OFF_SAPI, 32'h4040);
        fr(8'h40, 8'h44, 2, 4'hc);
        chk("equal sapi code", {s[11:10], s[8]} == 3'h1, 32'h0);
        apb(1'h1, hfs_pkg::OFF_SAPI, 32'h8040);
    endtask
    task automatic t_modes;
        apb(1'h1, hfs_pkg::OFF_MODE, 32'h01);
        fr(8'h22, 8'h00, 1, 4'hc);
        chk("one byte first tei", s[8], 32'h1);
        fr(8'h44, 8'h00, 1, 4'hc);
        chk("one byte second tei", s[8], 32'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, hfs_pkg::OFF_MODE, md[i]);
            fr(8'h40, 8'h22, 2, 4'hc);
            chk("mode code", {s[11:10], s[8] & (i != 0)}, mx[i]);
        end
        apb(1'h1, hfs_pkg::OFF_MODE, 32'h11);
    endtask
    task automatic t_errors;
        fr(8'h40, 8'h22, 2, 4'ha);
        chk("drop and bad crc", s[15:12], 32'hc);
        fr(8'h40, 8'h22, 2, 4'hc);
        chk("drop cleared", s[14], 32'h0);
        fr(8'h40, 8'h22, 2, 4'h5);
        chk("abort bits", s[15:12], 32'h3);
        chk("receiver idle", s[7], 32'h0);
        rd(hfs_pkg::OFF_INT_STAT);
        chk("abort event", s[1], 32'h1);
        fr(8'h40, 8'h22, 2, 4'hc);
        chk("receiver active", s[7], 32'h1);
    endtask
    task automatic t_irq;
        rd(hfs_pkg::OFF_INT_STAT);
        @(posedge clk);
        chk("irq idle", irq, 32'h0);
        fr(8'h40, 8'h22, 2, 4'hc);
        chk("irq on frame end", irq, 32'h1);
        rd(hfs_pkg::OFF_INT_STAT);
        chk("end event", s[0], 32'h1);
        @(posedge clk);
        chk("irq cleared", irq, 32'h0);
        apb(1'h1, hfs_pkg::OFF_INT_MASK, 32'h1);
        fr(8'h40, 8'h22, 2, 4'hc);
        chk("irq masked", irq, 32'h0);
        rd(hfs_pkg::OFF_INT_STAT);
        chk("masked event seen", s[0], 32'h1);
        apb(1'h1, hfs_pkg::OFF_INT_MASK, 32'h0);
    endtask
    task automatic t_tx;
        transparent_tx_cmd <= 1'h1;
        @(posedge clk);
        transparent_tx_cmd <= 1'h0;
        rd(hfs_pkg::OFF_STATUS);
        chk("tx active", s[0], 32'h1);
        rd(hfs_pkg::OFF_STATUS);
        chk("tx still active", s[0], 32'h1);
        tx_frame_sent <= 1'h1;
        @(posedge clk);
        tx_frame_sent <= 1'h0;
        rd(hfs_pkg::OFF_STATUS);
        chk("tx done", s[0], 32'h0);
    endtask
    initial begin
        {clk, psel, penable, pwrite, transparent_tx_cmd} = 5'h0;
        {paddr, pwdata, tx_frame_sent, q_last} = 57'h0;
        err_count = 0;
        checked = 0;
        cyc = 0;
        reset = 1'h1;
        repeat (2) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        t_reset;
        t_codes;
        t_modes;
        t_errors;
        t_irq;
        t_tx;
        end_of_test;
    end
endmodule // hdlc_frame_status_addr_match_tb
